// ===== design/lcc_params.svh
// Offsets, field positions and reset values of the logic cluster control block
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define LCC_ADDR_SRC       8'h00
`define LCC_ADDR_USE       8'h04
`define LCC_ADDR_STATUS    8'h08
`define LCC_ADDR_Q         8'h0c
`define LCC_ADDR_CELL      8'h40
`define LCC_ADDR_CELL_END  8'h7c

// ----------------------------------------------------------------------------
// Control signal slots, four bits of source select each in the SRC register
// ----------------------------------------------------------------------------
`define LCC_NUM_CTRL       8
`define LCC_SIG_CLK1       0
`define LCC_SIG_ENA1       1
`define LCC_SIG_CLK2       2
`define LCC_SIG_ENA2       3
`define LCC_SIG_ACLR_A     4
`define LCC_SIG_ACLR_B     5
`define LCC_SIG_SCLR       6
`define LCC_SIG_SLOAD      7
`define LCC_SRC_LOCAL_BIT  3

// ----------------------------------------------------------------------------
// USE register and per-cell configuration fields
// ----------------------------------------------------------------------------
`define LCC_USE_DUAL       8
`define LCC_CFG_CLK2       0
`define LCC_CFG_CLR_B      1
`define LCC_CFG_CLR_USE    2
`define LCC_CFG_PRESET     3
`define LCC_CFG_MODE_LO    4
`define LCC_CFG_CHAIN      6
`define LCC_CFG_PACKED     7

// ----------------------------------------------------------------------------
// Limits, reset values and bus answers
// ----------------------------------------------------------------------------
`define LCC_MAX_USED       4'd7
`define LCC_MAX_NONGLOBAL  4'd4
`define LCC_SRC_RESET      32'h0000_0000
`define LCC_USE_RESET      9'h000
`define LCC_CELL_RESET     8'h00
`define LCC_RESP_OKAY      2'b00
`define LCC_RESP_SLVERR    2'b10

`endif

// ===== design/lcc_pkg.sv
// Types shared by the logic cluster control block
package lcc_pkg;

  // Flip-flop personality of one cell register
  typedef enum logic [1:0] {
    mode_d  = 2'h0,
    mode_t  = 2'h1,
    mode_jk = 2'h2,
    mode_sr = 2'h3
  } lcc_mode_t;

  // Register bus write sequencing
  typedef enum logic [1:0] {
    wr_idle = 2'b01,
    wr_resp = 2'b10
  } lcc_wr_state_t;

endpackage

// ===== design/lcc_cluster.sv
// Control signal generation and cell registers of one sixteen-cell logic cluster
//
// Summary of operation
// - Eight control slots, at most seven in use
// - Synchronous load removes first clock enable
// - Packed cells ignore synchronous load
// - At most four control signals from local routing
// - Sync clear acts on all cells, sync load on unpacked cells only
// - Each cluster clock paired with its enable
// - Dual-edge clocking occupies both cluster clocks
// - Deasserted enable holds the registers
// - Sources: six row lines or local routing
// - Two selectable asynchronous clears per cluster
// - Preset only through inversion, never with clear
// - Chip-wide clear overrides everything when enabled
// - Register chain feeds next cell's register
// - Cell register in D, T, JK, SR
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`include "lcc_params.svh"

module lcc_cluster #(
  parameter int CELLS         = 16,
  parameter int ROW_LINES     = 6,
  parameter int LOCAL_LINES   = 8,
  parameter bit CHIP_CLEAR_EN = 1'b1,
  parameter int ADDR_W        = 8
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic [ROW_LINES-1:0]   i_row_clock,
  input  wire logic [LOCAL_LINES-1:0] i_local_line,
  input  wire logic [CELLS-1:0]       i_cell_data,
  input  wire logic [CELLS-1:0]       i_cell_aux,
  input  wire logic [CELLS-1:0]       i_load_data,
  input  wire logic                   i_chain_in,
  input  wire logic                   i_chip_wide_clear_n,
  output logic      [CELLS-1:0]       o_cell_q,
  input  wire logic [ADDR_W-1:0]      i_axi_awaddr,
  input  wire logic                   i_axi_awvalid,
  output logic                        o_axi_awready,
  input  wire logic [31:0]            i_axi_wdata,
  input  wire logic [3:0]             i_axi_wstrb,
  input  wire logic                   i_axi_wvalid,
  output logic                        o_axi_wready,
  output logic [1:0]                  o_axi_bresp,
  output logic                        o_axi_bvalid,
  input  wire logic                   i_axi_bready,
  input  wire logic [ADDR_W-1:0]      i_axi_araddr,
  input  wire logic                   i_axi_arvalid,
  output logic                        o_axi_arready,
  output logic [31:0]                 o_axi_rdata,
  output logic [1:0]                  o_axi_rresp,
  output logic                        o_axi_rvalid,
  input  wire logic                   i_axi_rready
);
  import lcc_pkg::*;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [31:0]       src_sel;
  logic [8:0]        use_cfg;
  logic [7:0]        cell_cfg [CELLS];
  logic              cfg_err;
  logic              err_used;
  logic              err_local;
  logic [3:0]        used_cnt;
  logic [3:0]        local_cnt;
  logic [7:0]        used_eff;
  logic [7:0]        sig_lvl;
  logic [7:0]        src_raw;
  logic              clk1_prev;
  logic              clk2_prev;
  logic              tick1;
  logic              tick2;
  logic              ena1_v;
  logic              ena2_v;
  logic              chip_clr;
  logic [CELLS-1:0]  next_cell_q;
  logic [CELLS-1:0]  upd_mask;
  logic [CELLS-1:0]  aclr_mask;
  logic [CELLS-1:0]  preset_mask;

  // --------------------------------------------------------------------------
  // Source selection and usage accounting
  // --------------------------------------------------------------------------
  // Each slot picks a row line or a local line; row codes past the last line read low
  always_comb begin
    for (int k = 0; k < `LCC_NUM_CTRL; k++) begin
      if (src_sel[4*k+`LCC_SRC_LOCAL_BIT]) begin
        src_raw[k] = i_local_line[src_sel[4*k +: 3]];
      end else if (int'(src_sel[4*k +: 3]) < ROW_LINES) begin
        src_raw[k] = i_row_clock[src_sel[4*k +: 3]];
      end else begin
        src_raw[k] = 1'b0;
      end
    end
  end

  // Sync load steals the first enable; dual-edge clocking claims the second clock
  always_comb begin
    used_eff = use_cfg[7:0];
    if (use_cfg[`LCC_SIG_SLOAD]) begin
      used_eff[`LCC_SIG_ENA1] = 1'b0;
    end
    if (use_cfg[`LCC_USE_DUAL]) begin
      used_eff[`LCC_SIG_CLK2] = 1'b1;
    end
  end

  // Count slots in use and those fed from local routing
  always_comb begin
    used_cnt  = 4'h0;
    local_cnt = 4'h0;
    for (int k = 0; k < `LCC_NUM_CTRL; k++) begin
      if (used_eff[k]) begin
        used_cnt = used_cnt + 4'h1;
        if (src_sel[4*k+`LCC_SRC_LOCAL_BIT] && !(k == `LCC_SIG_CLK2 && use_cfg[`LCC_USE_DUAL])) begin
          local_cnt = local_cnt + 4'h1;
        end
      end
    end
    err_used  = (used_cnt > `LCC_MAX_USED);
    err_local = (local_cnt > `LCC_MAX_NONGLOBAL);
    cfg_err   = err_used || err_local;
  end

  // Unused slots fall back to their idle level: enables high, clears low
  always_comb begin
    for (int k = 0; k < `LCC_NUM_CTRL; k++) begin
      sig_lvl[k] = used_eff[k] ? src_raw[k] : 1'b0;
    end
    ena1_v   = used_eff[`LCC_SIG_ENA1] ? src_raw[`LCC_SIG_ENA1] : 1'b1;
    ena2_v   = used_eff[`LCC_SIG_ENA2] ? src_raw[`LCC_SIG_ENA2] : 1'b1;
    chip_clr = CHIP_CLEAR_EN && !i_chip_wide_clear_n;
  end

  // --------------------------------------------------------------------------
  // Cluster clocks as one-cycle edge pulses of the system clock
  // --------------------------------------------------------------------------
  // Previous levels of both clock sources for edge detection
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clk1_prev <= 1'b0;
      clk2_prev <= 1'b0;
    end else begin
      clk1_prev <= sig_lvl[`LCC_SIG_CLK1];
      clk2_prev <= sig_lvl[`LCC_SIG_CLK2];
    end
  end

  // A bad configuration stops both clocks rather than run an illegal cluster
  always_comb begin
    tick1 = !cfg_err && sig_lvl[`LCC_SIG_CLK1] && !clk1_prev;
    if (use_cfg[`LCC_USE_DUAL]) begin
      tick2 = !cfg_err && !sig_lvl[`LCC_SIG_CLK1] && clk1_prev;
    end else begin
      tick2 = !cfg_err && sig_lvl[`LCC_SIG_CLK2] && !clk2_prev;
    end
  end

  dual_edge_a: assert property (use_cfg[`LCC_USE_DUAL] && !cfg_err && clk1_prev &&
                                !src_raw[`LCC_SIG_CLK1] |-> tick2 && !tick1)
    else $error("falling edge did not clock the second cluster clock");
  ena1_taken_a: assert property (use_cfg[`LCC_SIG_SLOAD] |-> ena1_v && !used_eff[`LCC_SIG_ENA1])
    else $error("first clock enable still usable under sync load");
  slot_limit_a: assert property (!cfg_err |-> used_cnt <= 4'd7 && local_cnt <= 4'd4)
    else $error("cluster clocking with too many control signals");
  local_stop_a: assert property (local_cnt > 4'd4 |-> !tick1 && !tick2)
    else $error("cluster clock ran with five local control signals");

  // --------------------------------------------------------------------------
  // Cell registers
  // --------------------------------------------------------------------------
  // Priority: chip clear, async clear, then clocked sync clear, sync load, data
  always_comb begin
    logic      tk;
    logic      en;
    logic      d;
    lcc_mode_t md;
    tk = 1'b0;
    en = 1'b0;
    d  = 1'b0;
    md = mode_d;
    for (int i = 0; i < CELLS; i++) begin
      tk = cell_cfg[i][`LCC_CFG_CLK2] ? tick2 : tick1;
      en = cell_cfg[i][`LCC_CFG_CLK2] ? ena2_v : ena1_v;
      md = lcc_mode_t'(cell_cfg[i][`LCC_CFG_MODE_LO +: 2]);
      if (cell_cfg[i][`LCC_CFG_CHAIN]) begin
        d = (i == 0) ? i_chain_in : o_cell_q[(i == 0) ? 0 : i-1];
      end else begin
        d = i_cell_data[i];
      end
      // Inverted push-back: a cleared preset cell reads one, so it has no true clear
      preset_mask[i] = cell_cfg[i][`LCC_CFG_PRESET];
      aclr_mask[i]   = cell_cfg[i][`LCC_CFG_CLR_USE] &&
                       (cell_cfg[i][`LCC_CFG_CLR_B] ? sig_lvl[`LCC_SIG_ACLR_B]
                                                    : sig_lvl[`LCC_SIG_ACLR_A]);
      upd_mask[i]    = tk && en;
      next_cell_q[i] = o_cell_q[i];
      if (chip_clr || aclr_mask[i]) begin
        next_cell_q[i] = preset_mask[i];
      end else if (upd_mask[i]) begin
        if (sig_lvl[`LCC_SIG_SCLR]) begin
          next_cell_q[i] = preset_mask[i];
        end else if (sig_lvl[`LCC_SIG_SLOAD] && !cell_cfg[i][`LCC_CFG_PACKED]) begin
          next_cell_q[i] = i_load_data[i];
        end else begin
          case (md)
            mode_d:  next_cell_q[i] = d;
            mode_t:  next_cell_q[i] = o_cell_q[i] ^ d;
            mode_jk: next_cell_q[i] = (d && !o_cell_q[i]) || (!i_cell_aux[i] && o_cell_q[i]);
            mode_sr: next_cell_q[i] = d || (!i_cell_aux[i] && o_cell_q[i]);
            default: next_cell_q[i] = o_cell_q[i];
          endcase
        end
      end
    end
  end

  // Every cell register of the cluster shares the same control set
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cell_q <= '0;
    end else begin
      o_cell_q <= next_cell_q;
    end
  end

  sequence s_sclr_edge;
    !chip_clr && aclr_mask == '0 && sig_lvl[`LCC_SIG_SCLR] && upd_mask != '0;
  endsequence
  sequence s_chain_step;
    !chip_clr && aclr_mask[1] == 1'b0 && upd_mask[1] && cell_cfg[1][7:3] == 5'b01000 &&
    !sig_lvl[`LCC_SIG_SCLR] && !sig_lvl[`LCC_SIG_SLOAD];
  endsequence

  sclr_all_cells_a: assert property (s_sclr_edge |=>
                                     ((o_cell_q ^ $past(preset_mask)) & $past(upd_mask)) == '0)
    else $error("sync clear missed a clocked cell");
  sclr_wins_a: assert property (s_sclr_edge ##0 sig_lvl[`LCC_SIG_SLOAD] |=>
                                (o_cell_q & $past(upd_mask) & ~$past(preset_mask)) == '0)
    else $error("sync load beat sync clear");
  chain_shift_a: assert property (s_chain_step ##1 1'b1 |-> o_cell_q[1] == $past(o_cell_q[0]))
    else $error("register chain did not shift");
  gated_hold_a: assert property (!chip_clr && aclr_mask == '0 |=>
                                 ((o_cell_q ^ $past(o_cell_q)) & ~$past(upd_mask)) == '0)
    else $error("cell changed without an enabled cluster clock");
  chip_clear_a: assert property (chip_clr |=> o_cell_q == $past(preset_mask))
    else $error("chip-wide clear did not clear every cell");
  packed_load_a: assert property (!chip_clr && !aclr_mask[5] && upd_mask[5] &&
                                  cell_cfg[5][7:3] == 5'b10000 && !sig_lvl[`LCC_SIG_SCLR] &&
                                  sig_lvl[`LCC_SIG_SLOAD] |=> o_cell_q[5] == $past(i_cell_data[5]))
    else $error("packed cell took the sync load");

  // --------------------------------------------------------------------------
  // Register bus slave
  // --------------------------------------------------------------------------
  lcc_wr_state_t     wr_state;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_cell(input logic [ADDR_W-1:0] a);
    return a[7:0] >= `LCC_ADDR_CELL && a[7:0] <= `LCC_ADDR_CELL_END;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a[7:0] == `LCC_ADDR_SRC || a[7:0] == `LCC_ADDR_USE || a[7:0] == `LCC_ADDR_STATUS ||
           a[7:0] == `LCC_ADDR_Q || is_cell(a);
  endfunction

  assign wr_go  = (wr_state == wr_idle) && aw_held && w_held;
  assign wr_hit = is_mapped(aw_addr);

  // Address and data are caught independently; the answer waits for both
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_state      <= wr_idle;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      o_axi_awready <= 1'b1;
      o_axi_wready  <= 1'b1;
      o_axi_bvalid  <= 1'b0;
      o_axi_bresp   <= `LCC_RESP_OKAY;
    end else begin
      case (wr_state)
        wr_idle: begin
          if (i_axi_awvalid && o_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= i_axi_awaddr;
            o_axi_awready <= 1'b0;
          end
          if (i_axi_wvalid && o_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= i_axi_wdata;
            w_strb       <= i_axi_wstrb;
            o_axi_wready <= 1'b0;
          end
          if (wr_go) begin
            o_axi_bvalid <= 1'b1;
            o_axi_bresp  <= wr_hit ? `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
            wr_state     <= wr_resp;
          end
        end
        wr_resp: begin
          if (i_axi_bready) begin
            o_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            o_axi_awready <= 1'b1;
            o_axi_wready  <= 1'b1;
            wr_state      <= wr_idle;
          end
        end
        default: wr_state <= wr_idle;
      endcase
    end
  end

  // Configuration writes; status and cell outputs are read-only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      src_sel <= `LCC_SRC_RESET;
      use_cfg <= `LCC_USE_RESET;
      for (int i = 0; i < CELLS; i++) begin
        cell_cfg[i] <= `LCC_CELL_RESET;
      end
    end else if (wr_go) begin
      if (aw_addr[7:0] == `LCC_ADDR_SRC) begin
        src_sel <= merge(src_sel, w_data, w_strb);
      end
      if (aw_addr[7:0] == `LCC_ADDR_USE) begin
        use_cfg <= 9'(merge({23'h0, use_cfg}, w_data, w_strb));
      end
      if (is_cell(aw_addr) && w_strb[0]) begin
        cell_cfg[aw_addr[5:2]] <= w_data[7:0];
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_axi_arready <= 1'b1;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0;
      o_axi_rresp   <= `LCC_RESP_OKAY;
    end else if (o_axi_rvalid) begin
      if (i_axi_rready) begin
        o_axi_rvalid  <= 1'b0;
        o_axi_arready <= 1'b1;
      end
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b1;
      o_axi_rresp   <= is_mapped(i_axi_araddr) ? `LCC_RESP_OKAY : `LCC_RESP_SLVERR;
      case (i_axi_araddr[7:0])
        `LCC_ADDR_SRC:    o_axi_rdata <= src_sel;
        `LCC_ADDR_USE:    o_axi_rdata <= {23'h0, use_cfg};
        `LCC_ADDR_STATUS: o_axi_rdata <= {16'h0, local_cnt, used_cnt, 5'h0, err_local, err_used, cfg_err};
        `LCC_ADDR_Q:      o_axi_rdata <= {{(32-CELLS){1'b0}}, o_cell_q};
        default:          o_axi_rdata <= is_cell(i_axi_araddr) ? {24'h0, cell_cfg[i_axi_araddr[5:2]]} : 32'h0;
      endcase
    end
  end

endmodule // lcc_cluster

// ===== verification/test_logic_cluster_register_control.sv
// Self-checking testbench of the logic cluster control block
`include "lcc_params.svh"
module test_logic_cluster_register_control;
  timeunit 1ns;
  timeprecision 1ps;
  import lcc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, bench state and the block
  // ----------------------------------------------------------------
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic [5:0]  i_row_clock = 6'h00;
  logic [7:0]  i_local_line = 8'h00;
  logic [15:0] i_cell_data = 16'h0000;
  logic [15:0] i_cell_aux = 16'h0000;
  logic [15:0] i_load_data = 16'h0000;
  logic        i_chain_in = 1'b0;
  logic        i_chip_wide_clear_n = 1'b1;
  logic [15:0] o_cell_q;
  logic [7:0]  i_axi_awaddr = 8'h00;
  logic [7:0]  i_axi_araddr = 8'h00;
  logic [31:0] i_axi_wdata = 32'h0;
  logic [3:0]  i_axi_wstrb = 4'h0;
  logic        i_axi_awvalid = 1'b0;
  logic        i_axi_wvalid = 1'b0;
  logic        i_axi_bready = 1'b0;
  logic        i_axi_arvalid = 1'b0;
  logic        i_axi_rready = 1'b0;
  logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0]  o_axi_bresp, o_axi_rresp;
  logic [31:0] o_axi_rdata;
  logic [15:0] exp_q;
  int          num_errors = 0;
  int          compares = 0;

  // Free-running 20 MHz system clock
  always #25 i_clk_sys = ~i_clk_sys;

  lcc_cluster lcc_cluster_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_row_clock(i_row_clock),
    .i_local_line(i_local_line), .i_cell_data(i_cell_data), .i_cell_aux(i_cell_aux),
    .i_load_data(i_load_data), .i_chain_in(i_chain_in), .i_chip_wide_clear_n(i_chip_wide_clear_n),
    .o_cell_q(o_cell_q), .i_axi_awaddr(i_axi_awaddr), .i_axi_awvalid(i_axi_awvalid),
    .o_axi_awready(o_axi_awready), .i_axi_wdata(i_axi_wdata), .i_axi_wstrb(i_axi_wstrb),
    .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp),
    .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready), .i_axi_araddr(i_axi_araddr),
    .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata),
    .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready));

  // ----------------------------------------------------------------
  // Compare, bus and clocking tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_word({30'h0, got}, {30'h0, exp});
  endtask
  task automatic check_q(input logic [15:0] exp);
    check_word({16'h0, o_cell_q}, {16'h0, exp});
  endtask

  // Readies come from flops, so the level seen at the falling edge is the one the next rise samples
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit aw_hit, w_hit, b_hit;
    int n;
    n = 0;
    b_hit = 1'b0;
    @(posedge i_clk_sys);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_wstrb <= s;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready} <= 3'b111;
    while (!b_hit && n < 200) begin
      @(negedge i_clk_sys);
      aw_hit = i_axi_awvalid && (o_axi_awready === 1'b1);
      w_hit = i_axi_wvalid && (o_axi_wready === 1'b1);
      b_hit = (o_axi_bvalid === 1'b1);
      r = b_hit ? o_axi_bresp : 2'bxx;
      @(posedge i_clk_sys);
      if (aw_hit) i_axi_awvalid <= 1'b0;
      if (w_hit) i_axi_wvalid <= 1'b0;
      if (b_hit) i_axi_bready <= 1'b0;
      n++;
    end
    if (!b_hit) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_hit, r_hit;
    int n;
    n = 0;
    r_hit = 1'b0;
    @(posedge i_clk_sys);
    i_axi_araddr <= a;
    {i_axi_arvalid, i_axi_rready} <= 2'b11;
    while (!r_hit && n < 200) begin
      @(negedge i_clk_sys);
      ar_hit = i_axi_arvalid && (o_axi_arready === 1'b1);
      r_hit = (o_axi_rvalid === 1'b1);
      d = r_hit ? o_axi_rdata : 32'hx;
      r = r_hit ? o_axi_rresp : 2'bxx;
      @(posedge i_clk_sys);
      if (ar_hit) i_axi_arvalid <= 1'b0;
      if (r_hit) i_axi_rready <= 1'b0;
      n++;
    end
    if (!r_hit) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check_resp(r, `LCC_RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_resp(r, `LCC_RESP_OKAY);
    check_word(d, e);
  endtask
  task automatic cells(input logic [7:0] even, input logic [7:0] odd);
    for (int i = 0; i < 16; i++) wr(`LCC_ADDR_CELL + 8'(4 * i), {24'h0, (i % 2) ? odd : even});
  endtask
  // One rising level on a row line, with cell data applied alongside
  task automatic tick(input int b, input logic [15:0] d, input logic [15:0] a);
    @(posedge i_clk_sys);
    i_cell_data <= d;
    i_cell_aux <= a;
    i_row_clock[b] <= 1'b1;
    @(posedge i_clk_sys);
    i_row_clock[b] <= 1'b0;
    #1;
  endtask
  // Expected next state of one cell register for each personality
  function automatic logic nq(input logic [1:0] m, input logic q, input logic d, input logic a);
    case (lcc_mode_t'(m))
      mode_d:  return d;
      mode_t:  return q ^ d;
      mode_jk: return (d & a) ? ~q : (d ? 1'b1 : (a ? 1'b0 : q));
      default: return d ? 1'b1 : (a ? 1'b0 : q);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    check_q(16'h0);
    rd_chk(`LCC_ADDR_USE, 32'h0);
    rd_chk(`LCC_ADDR_CELL_END, 32'h0);
    axi_read(8'h10, d, r);
    check_resp(r, `LCC_RESP_SLVERR);
    axi_write(8'h10, 32'h1, 4'hf, r);
    check_resp(r, `LCC_RESP_SLVERR);
    axi_write(`LCC_ADDR_SRC, 32'hffff_ffff, 4'b0010, r);
    rd_chk(`LCC_ADDR_SRC, 32'h0000_ff00);
    wr(`LCC_ADDR_STATUS, 32'hffff_ffff);
    rd_chk(`LCC_ADDR_STATUS, 32'h0);
  endtask
  task automatic t_modes();
    logic [15:0] d, a;
    wr(`LCC_ADDR_SRC, 32'h0);
    wr(`LCC_ADDR_USE, 32'h1);
    for (int i = 0; i < 16; i++) wr(`LCC_ADDR_CELL + 8'(4 * i), 32'(i % 4) << 4);
    exp_q = 16'h0;
    for (int k = 0; k < 3; k++) begin
      d = 16'ha5c3 ^ 16'(k * 16'h3f11);
      a = (16'h3a1c + 16'(k)) & ~(d & 16'h8888);
      for (int i = 0; i < 16; i++) exp_q[i] = nq(2'(i % 4), exp_q[i], d[i], a[i]);
      tick(0, d, a);
      check_q(exp_q);
    end
    tick(1, 16'hffff, 16'h0);
    check_q(exp_q);
  endtask
  task automatic t_enable();
    wr(`LCC_ADDR_SRC, 32'h0000_0480);
    wr(`LCC_ADDR_USE, 32'h7);
    for (int i = 0; i < 16; i++) wr(`LCC_ADDR_CELL + 8'(4 * i), (i > 7) ? 32'h1 : 32'h0);
    tick(0, 16'h5a5a, 16'h0);
    check_q(exp_q);
    @(posedge i_clk_sys);
    i_local_line <= 8'h01;
    tick(0, 16'h5a5a, 16'h0);
    exp_q[7:0] = 8'h5a;
    check_q(exp_q);
    tick(4, 16'hc3c3, 16'h0);
    exp_q[15:8] = 8'hc3;
    check_q(exp_q);
  endtask
  task automatic t_sync();
    wr(`LCC_ADDR_SRC, 32'h2100_0080);
    wr(`LCC_ADDR_USE, 32'hc3);
    cells(8'h00, 8'h00);
    wr(`LCC_ADDR_CELL + 8'h14, 32'h80);
    @(posedge i_clk_sys);
    i_local_line <= 8'h00;
    tick(0, 16'h1234, 16'h0);
    check_q(16'h1234);
    @(posedge i_clk_sys);
    i_row_clock[2] <= 1'b1;
    i_load_data <= 16'hbeef;
    tick(0, 16'h0f0f, 16'h0);
    check_q(16'hbecf);
    @(posedge i_clk_sys);
    i_row_clock[1] <= 1'b1;
    tick(0, 16'hffff, 16'h0);
    check_q(16'h0);
    @(posedge i_clk_sys);
    i_row_clock[2:1] <= 2'b00;
  endtask
  task automatic t_clear();
    wr(`LCC_ADDR_SRC, 32'h0043_0000);
    wr(`LCC_ADDR_USE, 32'h31);
    cells(8'h04, 8'h06);
    tick(0, 16'hffff, 16'h0);
    @(posedge i_clk_sys);
    i_chip_wide_clear_n <= 1'b0;
    tick(0, 16'hffff, 16'h0);
    check_q(16'h0);
    @(posedge i_clk_sys);
    i_chip_wide_clear_n <= 1'b1;
    tick(0, 16'hffff, 16'h0);
    wr(`LCC_ADDR_CELL, 32'hc);
    @(posedge i_clk_sys);
    i_row_clock[3] <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    check_q(16'haaab);
    @(posedge i_clk_sys);
    i_row_clock[4:3] <= 2'b10;
    @(posedge i_clk_sys);
    #1;
    check_q(16'h0001);
    @(posedge i_clk_sys);
    i_row_clock[4] <= 1'b0;
    exp_q = 16'h0001;
  endtask
  task automatic t_chain();
    logic [3:0] pat;
    pat = 4'b1011;
    wr(`LCC_ADDR_SRC, 32'h0);
    wr(`LCC_ADDR_USE, 32'h1);
    cells(8'h40, 8'h40);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk_sys);
      i_chain_in <= pat[k];
      tick(0, 16'h0, 16'h0);
      exp_q = {exp_q[14:0], pat[k]};
      check_q(exp_q);
    end
  endtask
  task automatic t_limits();
    wr(`LCC_ADDR_USE, 32'hff);
    rd_chk(`LCC_ADDR_STATUS, 32'h700);
    wr(`LCC_ADDR_USE, 32'h101);
    rd_chk(`LCC_ADDR_STATUS, 32'h200);
    // Cell 0 on the second clock follows the falling edge, one cycle after the chain shifts
    wr(`LCC_ADDR_CELL, 32'h1);
    tick(0, 16'h0000, 16'h0);
    exp_q = {exp_q[14:0], exp_q[0]};
    check_q(exp_q);
    @(posedge i_clk_sys);
    #1;
    exp_q[0] = 1'b0;
    check_q(exp_q);
    wr(`LCC_ADDR_SRC, 32'h000c_ba98);
    wr(`LCC_ADDR_USE, 32'h1f);
    rd_chk(`LCC_ADDR_STATUS, 32'h5505);
    @(posedge i_clk_sys);
    i_local_line <= 8'h1f;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check_q(exp_q);
    @(posedge i_clk_sys);
    i_local_line <= 8'h00;
  endtask

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well beyond the few hundred cycles the sequence needs
  initial begin
    #1_500_000;
    num_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_regs();
    t_modes();
    t_enable();
    t_sync();
    t_clear();
    t_chain();
    t_limits();
    wrap_up();
  end
endmodule // test_logic_cluster_register_control
